// ==== src/asr_pkg.sv ====
// constants, types and helpers for the angle sensor register bank
package asr_pkg;

  localparam int ADDR_W     = 14;
  localparam int WORD_W     = 16;
  localparam logic [4:0] FRAME_BITS = 5'h10;

  localparam logic [13:0] ADDR_IDLE     = 14'h0000;
  localparam logic [13:0] ADDR_FAULT    = 14'h0001;
  localparam logic [13:0] ADDR_BURN     = 14'h0003;
  localparam logic [13:0] ADDR_ZERO_HI  = 14'h0016;
  localparam logic [13:0] ADDR_ZERO_LO  = 14'h0017;
  localparam logic [13:0] ADDR_CFG_ONE  = 14'h0018;
  localparam logic [13:0] ADDR_CFG_TWO  = 14'h0019;
  localparam logic [13:0] ADDR_DIAG     = 14'h3ffc;
  localparam logic [13:0] ADDR_STRENGTH = 14'h3ffd;
  localparam logic [13:0] ADDR_RAW      = 14'h3ffe;
  localparam logic [13:0] ADDR_PRED     = 14'h3fff;

  // fault_flags fields
  localparam int FLT_FRAME  = 0;
  localparam int FLT_ADDR   = 1;
  localparam int FLT_PARITY = 2;

  // burn_control fields
  localparam int BRN_ENABLE = 0;
  localparam int BRN_RELOAD = 2;
  localparam int BRN_START  = 3;
  localparam int BRN_VERIFY = 6;
  localparam logic [7:0] BRN_MASK = 8'h4d;

  // diagnostics_gain fields
  localparam int DG_WEAK   = 11;
  localparam int DG_STRONG = 10;
  localparam int DG_COF    = 9;
  localparam int DG_LOOP   = 8;
  localparam logic [7:0] GAIN_MAX = 8'hff;
  localparam logic [7:0] GAIN_MIN = 8'h00;

  // zero_low_bits fields
  localparam int ZL_STRONG_EN = 6;
  localparam int ZL_WEAK_EN   = 7;

  // config_one fields
  localparam int C1_FACTORY = 0;
  localparam int C1_DIR     = 2;
  localparam int C1_PINSEL  = 3;
  localparam int C1_NOPRED  = 4;
  localparam int C1_BINARY  = 5;
  localparam int C1_SOURCE  = 6;
  localparam int C1_PULSE   = 7;

  localparam logic [7:0]  NV_RESET     = 8'h00;
  localparam logic [7:0]  CFG1_RESET   = 8'h01;
  localparam logic [15:0] FAULT_RESET  = 16'h0000;
  localparam logic [15:0] BURN_RESET   = 16'h0000;
  localparam logic [1:0]  LOAD_DELAY   = 2'h2;
  localparam logic [2:0]  PP_TOP_CODE  = 3'h7;

  typedef enum logic [0:0]
  {
    ASR_PH_CMD  = 1'b0,
    ASR_PH_DATA = 1'b1
  } asr_phase_t;

  function automatic logic asr_par_ok(input logic [15:0] w);
    return w[15] == (^w[14:0]);
  endfunction

  function automatic logic [15:0] asr_with_par(input logic [14:0] v);
    return {^v, v};
  endfunction

endpackage

// ==== src/asr_sync.sv ====
// two-stage synchroniser for link pins
`timescale 1ns/10ps
module asr_sync #(
  parameter int         WIDTH     = 3,
  parameter logic [2:0] RESET_VAL = 3'h0
) (
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  input  wire logic [WIDTH-1:0] d_in,
  output logic      [WIDTH-1:0] q_out
);

  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      meta_reg <= RESET_VAL[WIDTH-1:0];
      q_out    <= RESET_VAL[WIDTH-1:0];
    end
    else
    begin
      meta_reg <= d_in;
      q_out    <= meta_reg;
    end
  end

endmodule

// ==== src/asr_otp.sv ====
// one-time programmable store, cleared only by power-on
`timescale 1ns/10ps
module asr_otp (
  input  wire logic        clk_in,
  input  wire logic        por_n_in,
  input  wire logic        burn_req_in,
  input  wire logic [31:0] wdata_in,
  output logic      [31:0] rdata_out,
  output logic             burned_out
);

  logic [31:0] mem_reg;

  // programming is accepted once only
  always_ff @(posedge clk_in or negedge por_n_in)
  begin
    if (!por_n_in)
    begin
      mem_reg    <= 32'h0000_0000;
      burned_out <= 1'b0;
    end
    else if (burn_req_in && !burned_out)
    begin
      mem_reg    <= wdata_in;
      burned_out <= 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge por_n_in)
  begin
    if (!por_n_in)
      rdata_out <= 32'h0000_0000;
    else
      rdata_out <= mem_reg;
  end

endmodule

// ==== src/asr_top.sv ====
// serial-reached register bank of the rotary angle sensor
//
// Function
// - every access is decoded from a 14-bit address in the command word.
// - reading address zero returns zero and changes nothing.
// - fault flags hold parity fault at bit 2, frame fault at bit 0.
// - bit 1 is set by any access to an unimplemented address.
// - reading the fault flags clears them all.
// - burn control has enable bit 0, start bit 3, verify bit 6.
// - burn control bit 2 reloads shadows from the one-time memory.
// - weak-field flag bit 11 at gain 0xff, strong bit 10 at 0x00.
// - diagnostics: overflow bit 9, loop done bit 8, gain bits 7:0.
// - uncompensated angle reads at 0x3ffe, bits 13:0.
// - compensated angle reads at the top address, bits 13:0.
// - config bit 6 picks compensated or computed angle at top address.
// - shadow registers take soft writes; hardware reset discards them.
// - one-time memory programs once, survives reset, cannot be rewritten.
// - unprogrammed shadows read zero except the fixed factory bit.
// - zero position is high byte 7:0 plus low register bits 5:0.
// - low register bits 6 and 7 enable field faults onto error flag.
// - config one bit 0 reads 1; host keeps bit 1 at 0.
// - config one bit 2 inverts direction, bit 4 disables prediction.
// - config one bit 3 selects quadrature or commutation output use.
// - config one bit 7 enables pulse output, bit 5 binary counts.
// - config two: pole pairs 2:0, deadband 4:3, resolution 7:5.
// - a write is parity command word then 16-bit data word; a read is the command word alone.
// - commands execute only at chip select rising edge.
// - read data captured at frame end, shifted out next frame.
// - wrong command parity sets the parity fault bit.
`timescale 1ns/10ps
module asr_top
  import asr_pkg::*;
(
  input  wire logic        CLK_IN,
  input  wire logic        RST_N_IN,
  input  wire logic        OTP_POR_N_IN,
  input  wire logic        CSN_IN,
  input  wire logic        SCLK_IN,
  input  wire logic        MOSI_IN,
  output logic             MISO_OUT,
  output logic             MISO_OE_OUT,
  input  wire logic [7:0]  GAIN_VALUE_IN,
  input  wire logic        CORDIC_OVERFLOW_IN,
  input  wire logic        OFFSET_LOOP_DONE_IN,
  input  wire logic [13:0] VECTOR_STRENGTH_IN,
  input  wire logic [13:0] COMPUTED_ANGLE_IN,
  input  wire logic [13:0] PREDICTED_ANGLE_IN,
  output logic [13:0]      ZERO_POSITION_OUT,
  output logic             FIELD_ERROR_OUT,
  output logic             DIR_INVERT_OUT,
  output logic             PULSE_PIN_SELECT_OUT,
  output logic             PREDICT_DISABLE_OUT,
  output logic             QUAD_BINARY_SEL_OUT,
  output logic             PULSE_OUTPUT_ENABLE_OUT,
  output logic [2:0]       POLE_PAIRS_OUT,
  output logic [1:0]       STEP_DEADBAND_OUT,
  output logic [2:0]       QUAD_STEP_RES_OUT,
  output logic             OTP_BURNED_OUT
);

  default clocking cb_main @(posedge CLK_IN);
  endclocking
  default disable iff (!RST_N_IN);

  //////////////////////////////////////////////////////////////////////////
  // link pin capture and edge finding

  logic [2:0]  pins_s;
  logic        csn_s;
  logic        sclk_s;
  logic        mosi_s;
  logic        csn_d_reg;
  logic        sclk_d_reg;
  logic        frame_start;
  logic        frame_end;
  logic        sclk_rise;
  logic        sclk_fall;

  asr_sync #(
    .WIDTH     (3),
    .RESET_VAL (3'h4)
  ) u_sync (
    .clk_in   (CLK_IN),
    .rst_n_in (RST_N_IN),
    .d_in     ({CSN_IN, SCLK_IN, MOSI_IN}),
    .q_out    (pins_s)
  );

  assign csn_s  = pins_s[2];
  assign sclk_s = pins_s[1];
  assign mosi_s = pins_s[0];

  always_ff @(posedge CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      csn_d_reg  <= 1'b1;
      sclk_d_reg <= 1'b0;
    end
    else
    begin
      csn_d_reg  <= csn_s;
      sclk_d_reg <= sclk_s;
    end
  end

  assign frame_start = csn_d_reg && !csn_s;
  assign frame_end   = !csn_d_reg && csn_s;
  assign sclk_rise   = !csn_s && !sclk_d_reg && sclk_s;
  assign sclk_fall   = !csn_s && sclk_d_reg && !sclk_s;

  //////////////////////////////////////////////////////////////////////////
  // receive shifter and bit counter

  logic [15:0] rx_reg;
  logic [4:0]  bit_cnt_reg;
  logic        frame_ok;
  logic        rx_par_ok;
  logic [13:0] rx_addr;
  logic        rx_is_read;

  always_ff @(posedge CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      rx_reg      <= 16'h0000;
      bit_cnt_reg <= 5'h00;
    end
    else if (frame_start)
      bit_cnt_reg <= 5'h00;
    else if (sclk_fall)
    begin
      rx_reg <= {rx_reg[14:0], mosi_s};
      if (bit_cnt_reg != 5'h1f)
        bit_cnt_reg <= bit_cnt_reg + 5'h01;
    end
  end

  assign frame_ok   = (bit_cnt_reg == FRAME_BITS);
  assign rx_par_ok  = asr_par_ok(rx_reg);
  assign rx_addr    = rx_reg[13:0];
  assign rx_is_read = rx_reg[14];

  //////////////////////////////////////////////////////////////////////////
  // register read decode

  logic [15:0] fault_reg;
  logic [15:0] burn_reg;
  logic [7:0]  zero_hi_reg;
  logic [7:0]  zero_lo_reg;
  logic [7:0]  cfg1_reg;
  logic [7:0]  cfg2_reg;
  logic [15:0] diag_word;
  logic [13:0] top_angle;

  always_comb
  begin
    diag_word            = 16'h0000;
    diag_word[DG_WEAK]   = (GAIN_VALUE_IN == GAIN_MAX);
    diag_word[DG_STRONG] = (GAIN_VALUE_IN == GAIN_MIN);
    diag_word[DG_COF]    = CORDIC_OVERFLOW_IN;
    diag_word[DG_LOOP]   = OFFSET_LOOP_DONE_IN;
    diag_word[7:0]       = GAIN_VALUE_IN;
  end

  assign top_angle = cfg1_reg[C1_SOURCE] ? COMPUTED_ANGLE_IN
                                         : PREDICTED_ANGLE_IN;

  function automatic logic addr_valid(input logic [13:0] a);
    return (a == ADDR_IDLE) || (a == ADDR_FAULT) || (a == ADDR_BURN) ||
           (a == ADDR_ZERO_HI) || (a == ADDR_ZERO_LO) ||
           (a == ADDR_CFG_ONE) || (a == ADDR_CFG_TWO) ||
           (a >= ADDR_DIAG);
  endfunction

  function automatic logic [13:0] read_value(input logic [13:0] a);
    logic [13:0] v;
    v = 14'h0000;
    unique case (a)
      ADDR_FAULT:    v = fault_reg[13:0];
      ADDR_BURN:     v = burn_reg[13:0];
      ADDR_ZERO_HI:  v = {6'h00, zero_hi_reg};
      ADDR_ZERO_LO:  v = {6'h00, zero_lo_reg};
      ADDR_CFG_ONE:  v = {6'h00, cfg1_reg};
      ADDR_CFG_TWO:  v = {6'h00, cfg2_reg};
      ADDR_DIAG:     v = diag_word[13:0];
      ADDR_STRENGTH: v = VECTOR_STRENGTH_IN;
      ADDR_RAW:      v = COMPUTED_ANGLE_IN;
      ADDR_PRED:     v = top_angle;
      default:       v = 14'h0000;
    endcase
    return v;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // frame execution at chip select release

  asr_phase_t  phase_reg;
  logic [13:0] pend_addr_reg;
  logic        pend_ok_reg;
  logic        cmd_end;
  logic        data_end;
  logic        cmd_good;
  logic        do_write;
  logic        clear_faults;
  logic [15:0] fault_set;

  assign cmd_end  = frame_end && (phase_reg == ASR_PH_CMD);
  assign data_end = frame_end && (phase_reg == ASR_PH_DATA);
  assign cmd_good = cmd_end && frame_ok && rx_par_ok;
  assign do_write = data_end && frame_ok && rx_par_ok && pend_ok_reg;
  assign clear_faults = cmd_good && rx_is_read && (rx_addr == ADDR_FAULT);

  always_comb
  begin
    fault_set             = 16'h0000;
    fault_set[FLT_FRAME]  = frame_end && !frame_ok;
    fault_set[FLT_PARITY] = frame_end && frame_ok && !rx_par_ok;
    fault_set[FLT_ADDR]   = cmd_good && !addr_valid(rx_addr);
  end

  always_ff @(posedge CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      phase_reg     <= ASR_PH_CMD;
      pend_addr_reg <= ADDR_IDLE;
      pend_ok_reg   <= 1'b0;
    end
    else if (cmd_end)
    begin
      pend_addr_reg <= rx_addr;
      pend_ok_reg   <= cmd_good && addr_valid(rx_addr);
      phase_reg     <= (cmd_good && !rx_is_read) ? ASR_PH_DATA
                                                 : ASR_PH_CMD;
    end
    else if (data_end)
      phase_reg <= ASR_PH_CMD;
  end

  // set wins over the read clear
  always_ff @(posedge CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
      fault_reg <= FAULT_RESET;
    else
      fault_reg <= (clear_faults ? 16'h0000 : fault_reg)
                   | fault_set;
  end

  //////////////////////////////////////////////////////////////////////////
  // burn control and one-time memory

  logic [31:0] otp_rdata;
  logic        otp_burned;
  logic        burn_req_reg;
  logic [1:0]  load_cnt_reg;
  logic        load_now;
  logic        burn_wr;

  assign burn_wr  = do_write && (pend_addr_reg == ADDR_BURN);
  assign load_now = (load_cnt_reg == 2'h1);

  always_ff @(posedge CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      burn_reg     <= BURN_RESET;
      burn_req_reg <= 1'b0;
    end
    else
    begin
      burn_req_reg <= burn_wr && rx_reg[BRN_START]
                      && rx_reg[BRN_ENABLE];
      if (burn_wr)
        burn_reg <= {8'h00, rx_reg[7:0] & BRN_MASK};
    end
  end

  // shadows load after reset release and on reload or verify
  always_ff @(posedge CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
      load_cnt_reg <= LOAD_DELAY;
    else if (burn_wr && (rx_reg[BRN_RELOAD] || rx_reg[BRN_VERIFY]))
      load_cnt_reg <= LOAD_DELAY;
    else if (load_cnt_reg != 2'h0)
      load_cnt_reg <= load_cnt_reg - 2'h1;
  end

  asr_otp u_otp (
    .clk_in      (CLK_IN),
    .por_n_in    (OTP_POR_N_IN),
    .burn_req_in (burn_req_reg),
    .wdata_in    ({cfg2_reg, cfg1_reg, zero_lo_reg, zero_hi_reg}),
    .rdata_out   (otp_rdata),
    .burned_out  (otp_burned)
  );

  //////////////////////////////////////////////////////////////////////////
  // non-volatile shadow registers

  always_ff @(posedge CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      zero_hi_reg <= NV_RESET;
      zero_lo_reg <= NV_RESET;
      cfg1_reg    <= CFG1_RESET;
      cfg2_reg    <= NV_RESET;
    end
    else if (load_now)
    begin
      zero_hi_reg <= otp_rdata[7:0];
      zero_lo_reg <= otp_rdata[15:8];
      cfg1_reg    <= {otp_rdata[23:17], 1'b1};
      cfg2_reg    <= otp_rdata[31:24];
    end
    else if (do_write)
    begin
      unique case (pend_addr_reg)
        ADDR_ZERO_HI: zero_hi_reg <= rx_reg[7:0];
        ADDR_ZERO_LO: zero_lo_reg <= rx_reg[7:0];
        ADDR_CFG_ONE: cfg1_reg    <= {rx_reg[7:1], 1'b1};
        ADDR_CFG_TWO: cfg2_reg    <= rx_reg[7:0];
        default:      cfg1_reg    <= cfg1_reg;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // settings driven to the output generators

  logic field_err;

  assign field_err = CORDIC_OVERFLOW_IN
    || (diag_word[DG_WEAK] && zero_lo_reg[ZL_WEAK_EN])
    || (diag_word[DG_STRONG] && zero_lo_reg[ZL_STRONG_EN]);

  always_ff @(posedge CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      ZERO_POSITION_OUT       <= 14'h0000;
      FIELD_ERROR_OUT         <= 1'b0;
      DIR_INVERT_OUT          <= 1'b0;
      PULSE_PIN_SELECT_OUT    <= 1'b0;
      PREDICT_DISABLE_OUT     <= 1'b0;
      QUAD_BINARY_SEL_OUT     <= 1'b0;
      PULSE_OUTPUT_ENABLE_OUT <= 1'b0;
      POLE_PAIRS_OUT          <= 3'h1;
      STEP_DEADBAND_OUT       <= 2'h0;
      QUAD_STEP_RES_OUT       <= 3'h0;
      OTP_BURNED_OUT          <= 1'b0;
    end
    else
    begin
      ZERO_POSITION_OUT       <= {zero_hi_reg, zero_lo_reg[5:0]};
      FIELD_ERROR_OUT         <= field_err;
      DIR_INVERT_OUT          <= cfg1_reg[C1_DIR];
      PULSE_PIN_SELECT_OUT    <= cfg1_reg[C1_PINSEL];
      PREDICT_DISABLE_OUT     <= cfg1_reg[C1_NOPRED];
      QUAD_BINARY_SEL_OUT     <= cfg1_reg[C1_BINARY];
      PULSE_OUTPUT_ENABLE_OUT <= cfg1_reg[C1_PULSE];
      POLE_PAIRS_OUT          <= (cfg2_reg[2:0] == PP_TOP_CODE)
                                 ? PP_TOP_CODE : cfg2_reg[2:0] + 3'h1;
      STEP_DEADBAND_OUT       <= cfg2_reg[4:3];
      QUAD_STEP_RES_OUT       <= cfg2_reg[7:5];
      OTP_BURNED_OUT          <= otp_burned;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // transmit word and shifter

  logic [15:0] tx_word_reg;
  logic [15:0] tx_shift_reg;
  logic        tx_refresh_reg;

  always_ff @(posedge CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      tx_word_reg    <= 16'h0000;
      tx_refresh_reg <= 1'b0;
    end
    else
    begin
      tx_refresh_reg <= do_write;
      if (cmd_end && !cmd_good)
        tx_word_reg <= asr_with_par({1'b1, 14'h0000});
      else if (cmd_good)
        tx_word_reg <= asr_with_par({1'b0, read_value(rx_addr)});
      else if (tx_refresh_reg)
        tx_word_reg <= asr_with_par({1'b0, read_value(pend_addr_reg)});
    end
  end

  always_ff @(posedge CLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
    begin
      tx_shift_reg <= 16'h0000;
      MISO_OUT     <= 1'b0;
    end
    else if (frame_start)
    begin
      tx_shift_reg <= tx_word_reg;
      MISO_OUT     <= 1'b0;
    end
    else if (sclk_rise)
    begin
      MISO_OUT     <= tx_shift_reg[15];
      tx_shift_reg <= {tx_shift_reg[14:0], 1'b0};
    end
  end

  assign MISO_OE_OUT = !csn_s;

  //////////////////////////////////////////////////////////////////////////
  // checks

  AST_FRAME_FAULT: assert property (frame_end && !frame_ok
    |=> fault_reg[FLT_FRAME])
    else $error("short or long frame did not set frame fault");

  AST_BAD_ADDR: assert property (cmd_good && !addr_valid(rx_addr)
    |=> fault_reg[FLT_ADDR])
    else $error("unimplemented address did not set fault");

  AST_PARITY: assert property (cmd_end && frame_ok && !rx_par_ok
    |=> fault_reg[FLT_PARITY])
    else $error("bad command parity did not set fault");

  AST_FAULT_CLEAR: assert property (clear_faults
    |=> fault_reg == 16'h0000
      && tx_word_reg[13:0] == $past(fault_reg[13:0]))
    else $error("fault read did not return and clear flags");

  AST_IDLE_READ: assert property (cmd_good && rx_is_read
    && rx_addr == ADDR_IDLE
    |=> tx_word_reg == 16'h0000 && $stable(fault_reg) && $stable(cfg1_reg))
    else $error("idle slot read had an effect");

  AST_WEAK_FIELD: assert property (cmd_good && rx_is_read
    && rx_addr == ADDR_DIAG
    |=> tx_word_reg[DG_WEAK] == ($past(GAIN_VALUE_IN) == GAIN_MAX))
    else $error("weak field flag wrong");

  AST_TOP_SELECT: assert property (cmd_good && rx_is_read
    && rx_addr == ADDR_PRED && cfg1_reg[C1_SOURCE]
    |=> tx_word_reg[13:0] == $past(COMPUTED_ANGLE_IN))
    else $error("top address source select wrong");

  AST_FACTORY_BIT: assert property (do_write
    && pend_addr_reg == ADDR_CFG_ONE
    |=> cfg1_reg == {$past(rx_reg[7:1]), 1'b1})
    else $error("config one write lost or factory bit cleared");

  AST_POLE_PAIRS: assert property (cfg2_reg[2:0] == PP_TOP_CODE
    |=> POLE_PAIRS_OUT == PP_TOP_CODE)
    else $error("pole pair code seven not seven");

  AST_EXEC_AT_END: assert property (!frame_end
    && load_cnt_reg == 2'h0 |=> $stable(zero_hi_reg))
    else $error("register changed outside frame end");

endmodule

// ==== bench/asr_host.sv ====
// host serial master model for the sensor link
`timescale 1ns/10ps
module asr_host (
  input  wire logic clk_in,
  input  wire logic miso_in,
  output logic      csn_out,
  output logic      sclk_out,
  output logic      mosi_out
);
  initial
  begin
    csn_out  = 1'b1;
    sclk_out = 1'b0;
    mosi_out = 1'b0;
  end

  task automatic wt(input int n);
    repeat (n) @(negedge clk_in);
  endtask

  // n clocks msb first; drive on rise, sample on fall
  task automatic xfer(input logic [15:0] w, input int n,
                      output logic [15:0] r);
    r = 16'h0000;
    csn_out = 1'b0;
    wt(40);
    for (int i = 15; i > 15 - n; i--)
    begin
      sclk_out = 1'b1;
      mosi_out = w[i];
      wt(8);
      r[i] = miso_in;
      sclk_out = 1'b0;
      wt(8);
    end
    wt(8);
    mosi_out = ~mosi_out;
    csn_out = 1'b1;
    wt(40);
  endtask
endmodule

// ==== bench/asr_top_tb.sv ====
// self-checking bench for the sensor register bank
`timescale 1ns/10ps
module asr_top_tb;
  import asr_pkg::*;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        por_n = 1'b0;
  logic        csn, sclk, mosi, miso;
  logic        miso_oe, miso_pin;
  logic [7:0]  gain = 8'h80;
  logic        cordic_overflow = 1'b0;
  logic        lp = 1'b1;
  logic [13:0] stren = 14'h1234;
  logic [13:0] comp = 14'h0abc;
  logic [13:0] pred = 14'h2def;
  logic [13:0] zpos;
  logic        ferr, dir, psel, pdis, qbin, pen, burned;
  logic [2:0]  pp, qres;
  logic [1:0]  step_deadband;
  logic [15:0] rx;
  int          err_total = 0;
  int          total_checks = 0;

  always #5 clk = ~clk;

  // undriven line shows the inverse of the last bit
  assign miso_pin = miso_oe ? miso : ~miso;

  asr_host host (.clk_in(clk), .miso_in(miso_pin), .csn_out(csn),
                 .sclk_out(sclk), .mosi_out(mosi));

  asr_top DUT (.CLK_IN(clk), .RST_N_IN(rst_n), .OTP_POR_N_IN(por_n),
    .CSN_IN(csn), .SCLK_IN(sclk), .MOSI_IN(mosi), .MISO_OUT(miso),
    .MISO_OE_OUT(miso_oe), .GAIN_VALUE_IN(gain), .CORDIC_OVERFLOW_IN(cordic_overflow),
    .OFFSET_LOOP_DONE_IN(lp), .VECTOR_STRENGTH_IN(stren),
    .COMPUTED_ANGLE_IN(comp), .PREDICTED_ANGLE_IN(pred),
    .ZERO_POSITION_OUT(zpos), .FIELD_ERROR_OUT(ferr),
    .DIR_INVERT_OUT(dir), .PULSE_PIN_SELECT_OUT(psel),
    .PREDICT_DISABLE_OUT(pdis), .QUAD_BINARY_SEL_OUT(qbin),
    .PULSE_OUTPUT_ENABLE_OUT(pen), .POLE_PAIRS_OUT(pp),
    .STEP_DEADBAND_OUT(step_deadband), .QUAD_STEP_RES_OUT(qres),
    .OTP_BURNED_OUT(burned));

  function automatic logic [15:0] pw(input logic [14:0] v);
    return {^v, v};
  endfunction

  task automatic chk(input string s, input logic [15:0] g,
                     input logic [15:0] e);
    total_checks++;
    if (g !== e)
    begin
      err_total++;
      $display("BAD %s exp %h got %h", s, e, g);
    end
  endtask

  task automatic wr(input logic [13:0] a, input logic [13:0] d);
    host.xfer(pw({1'b0, a}), 16, rx);
    host.xfer(pw({1'b0, d}), 16, rx);
  endtask

  // answer comes back during the following idle read
  task automatic rd(input logic [13:0] a, input logic [13:0] e);
    host.xfer(pw({1'b1, a}), 16, rx);
    host.xfer(pw({1'b1, ADDR_IDLE}), 16, rx);
    chk($sformatf("addr %h", a), rx, pw({1'b0, e}));
  endtask

  task automatic hw_reset();
    rst_n = 1'b0;
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    repeat (10) @(negedge clk);
  endtask

  task automatic summarize();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial
  begin
    #1ms;
    err_total++;
    summarize();
  end

  initial
  begin
    repeat (8) @(negedge clk);
    por_n = 1'b1;
    rst_n = 1'b1;
    repeat (10) @(negedge clk);
    chk("oe", {15'h0, miso_oe}, 16'h0000);
    rd(ADDR_IDLE, 14'h0000);
    rd(ADDR_FAULT, 14'h0000);
    rd(ADDR_BURN, 14'h0000);
    rd(ADDR_ZERO_LO, 14'h0000);
    rd(ADDR_CFG_ONE, 14'h0001);
    rd(ADDR_DIAG, 14'h0180);
    rd(ADDR_STRENGTH, stren);
    rd(ADDR_RAW, comp);
    rd(ADDR_PRED, pred);
    gain = 8'hff;
    cordic_overflow = 1'b1;
    rd(ADDR_DIAG, 14'h0bff);
    gain = 8'h00;
    cordic_overflow = 1'b0;
    lp = 1'b0;
    rd(ADDR_DIAG, 14'h0400);
    wr(ADDR_DIAG, 14'h0000);
    rd(ADDR_DIAG, 14'h0400);
    wr(ADDR_CFG_ONE, 14'h0040);
    rd(ADDR_PRED, comp);
    wr(ADDR_ZERO_HI, 14'h00a5);
    wr(ADDR_ZERO_LO, 14'h00ff);
    chk("zpos", {2'b00, zpos}, 16'h297f);
    chk("ferr", {15'h0, ferr}, 16'h0001);
    gain = 8'h80;
    repeat (4) @(negedge clk);
    chk("ferr", {15'h0, ferr}, 16'h0000);
    wr(ADDR_CFG_ONE, 14'h00bc);
    rd(ADDR_CFG_ONE, 14'h00bd);
    chk("cfg1", {11'h0, dir, psel, pdis, qbin, pen}, 16'h001f);
    wr(ADDR_CFG_TWO, 14'h00b7);
    rd(ADDR_CFG_TWO, 14'h00b7);
    chk("cfg2", {8'h0, qres, step_deadband, pp}, 16'h00b7);
    wr(ADDR_CFG_TWO, 14'h0000);
    chk("pp", {13'h0, pp}, 16'h0001);
    host.xfer(pw({1'b1, 14'h0002}), 16, rx);
    rd(ADDR_FAULT, 14'h0002);
    wr(14'h0005, 14'h00ff);
    rd(ADDR_FAULT, 14'h0002);
    rd(ADDR_FAULT, 14'h0000);
    host.xfer(pw({1'b1, ADDR_RAW}) ^ 16'h8000, 16, rx);
    host.xfer(pw({1'b1, ADDR_IDLE}), 16, rx);
    chk("ef", rx, 16'hc000);
    rd(ADDR_FAULT, 14'h0004);
    host.xfer(pw({1'b0, ADDR_ZERO_LO}), 16, rx);
    host.xfer(pw({1'b0, 14'h0011}) ^ 16'h8000, 16, rx);
    rd(ADDR_FAULT, 14'h0004);
    rd(ADDR_ZERO_LO, 14'h00ff);
    host.xfer(pw({1'b1, ADDR_RAW}), 15, rx);
    rd(ADDR_FAULT, 14'h0001);
    hw_reset();
    rd(ADDR_ZERO_HI, 14'h0000);
    wr(ADDR_ZERO_HI, 14'h003c);
    wr(ADDR_CFG_TWO, 14'h0012);
    wr(ADDR_BURN, 14'h0009);
    chk("burned", {15'h0, burned}, 16'h0001);
    wr(ADDR_ZERO_HI, 14'h0077);
    wr(ADDR_BURN, 14'h0004);
    rd(ADDR_ZERO_HI, 14'h003c);
    wr(ADDR_ZERO_HI, 14'h0011);
    wr(ADDR_BURN, 14'h0009);
    hw_reset();
    rd(ADDR_ZERO_HI, 14'h003c);
    rd(ADDR_CFG_TWO, 14'h0012);
    wr(ADDR_ZERO_HI, 14'h0022);
    wr(ADDR_BURN, 14'h0040);
    rd(ADDR_ZERO_HI, 14'h003c);
    summarize();
  end
endmodule
